// ===== inc/rvs_pkg.sv
// Functional notes
// R1: All reset causes use the single reset vector
// R2: Programmed boot fuse starts at boot address
// R3: Fuse 1 unprogrammed to zero, 0 programmed
// R4: Relocate bit moves table to boot section
// R5: Relocated address is default plus boot start
// R6: Table starts 0x001 or boot plus 0x001
// R7: External requests zero, one at 0x001, 0x002
// R8: Pin changes 0x003-0x005, watchdog at 0x006
// R9: Timer2 compare A, B, overflow at 0x007-0x009
// R10: Timer1 capture, compares, overflow at 0x00A-0x00D
// R11: Timer0 compare A, B, overflow at 0x00E-0x010
// R12: Serial transfer complete at 0x011
// R13: Serial port events at 0x012 to 0x014
// R14: Converter, eeprom, comparator, two-wire, store at 0x015-0x019
// R15: Code in vectors only if interrupts unused
// R16: Reset and table may sit apart
// R17: One word per vector, start plus N-2
// R18: Lowest pending vector number wins
// R19: Vector address and identity for one cycle
package rvs_pkg;

  // ==========================================================
  // Address layout
  localparam int          RVS_PC_WIDTH     = 12;
  localparam logic [11:0] RVS_RESET_ADDR   = 12'h000;
  localparam logic [11:0] RVS_TABLE_OFFSET = 12'h001;
  localparam logic [11:0] RVS_BOOT_DEFAULT = 12'hC00;
  localparam int          RVS_NUM_SOURCES  = 25;
  localparam int          RVS_IDX_WIDTH    = 5;
  // Interrupt sources use vector numbers from two upwards
  localparam logic [4:0]  RVS_FIRST_IRQ_NUM = 5'h02;

  // ==========================================================
  // Source bit positions, bit i sits at table start plus i
  localparam int RVS_SRC_EXT_ZERO     = 0;  // R7
  localparam int RVS_SRC_EXT_ONE      = 1;
  localparam int RVS_SRC_PIN_CHANGE_0 = 2;  // R8
  localparam int RVS_SRC_WATCHDOG     = 5;
  localparam int RVS_SRC_T2_COMPARE_A = 6;  // R9
  localparam int RVS_SRC_T1_CAPTURE   = 9;  // R10
  localparam int RVS_SRC_T0_COMPARE_A = 13; // R11
  localparam int RVS_SRC_SERIAL_DONE  = 16; // R12
  localparam int RVS_SRC_USART_RX     = 17; // R13
  localparam int RVS_SRC_CONVERTER    = 20; // R14
  localparam int RVS_SRC_STORE_READY  = 24;

  typedef enum logic [1:0] {
    RVS_ST_BOOT,
    RVS_ST_RUN,
    RVS_ST_GAP
  } rvs_state_type;

endpackage

// ===== inc/rvs_pick_if.sv
`timescale 1ns/1ps
interface rvs_pick_if #(
  parameter int N  = 25,
  parameter int IW = 5
);
  logic [N-1:0]  pending;
  logic          any;
  logic [IW-1:0] index;

  // Encoder side and consumer side
  modport enc  (input pending, output any, index);
  modport user (output pending, input any, index);
endinterface

// ===== verilog/rvs_priority.sv
`timescale 1ns/1ps
module rvs_priority
  import rvs_pkg::*;
#(
  parameter int N  = 25,
  parameter int IW = 5
) (
  rvs_pick_if.enc pick
);

  // ==========================================================
  // Lowest index wins, scanned from the top down
  always_comb begin
    pick.any   = 1'b0;
    pick.index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pick.pending[i]) begin
        pick.any   = 1'b1; // R18
        pick.index = IW'(i);
      end
    end
  end

endmodule // rvs_priority

// ===== verilog/rvs_vector_select.sv
`timescale 1ns/1ps
module rvs_vector_select
  import rvs_pkg::*;
#(
  parameter int          NUM_SOURCES = RVS_NUM_SOURCES,
  parameter logic [11:0] BOOT_START  = RVS_BOOT_DEFAULT
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    boot_reset_fuse,
  input  wire logic                    vector_table_relocate,
  input  wire logic [NUM_SOURCES-1:0]  irq_pending,
  input  wire logic                    core_take,
  output logic                         pc_load,
  output logic [RVS_PC_WIDTH-1:0]      pc_next,
  output logic                         pc_from_reset,
  output logic                         irq_ack,
  output logic [RVS_IDX_WIDTH-1:0]     irq_vector_num,
  output logic                         boot_reset_active
);

  // ==========================================================
  // Fuse synchroniser
  // The fuse level comes from outside the clock domain.
  logic fuse_meta;
  logic fuse_sync;

  always_ff @(posedge clk) begin
    fuse_meta <= boot_reset_fuse;
    fuse_sync <= fuse_meta;
  end

  // ==========================================================
  // Priority pick
  rvs_pick_if #(.N(NUM_SOURCES), .IW(RVS_IDX_WIDTH)) pick ();

  assign pick.pending = irq_pending;

  rvs_priority #(
    .N  (NUM_SOURCES),
    .IW (RVS_IDX_WIDTH)
  ) u_priority (
    .pick (pick.enc)
  );

  // ==========================================================
  // Address decode
  rvs_state_type              state;
  rvs_state_type              next_state;
  logic                       fuse_programmed;
  logic [RVS_PC_WIDTH-1:0]    reset_addr;
  logic [RVS_PC_WIDTH-1:0]    table_start;
  logic [RVS_PC_WIDTH-1:0]    irq_addr;
  logic [RVS_IDX_WIDTH-1:0]   irq_num;
  logic                       take_irq;

  // Fuse value zero means programmed
  assign fuse_programmed = ~fuse_sync; // R3
  // Every reset cause lands on one vector
  assign reset_addr  = fuse_programmed ? BOOT_START : RVS_RESET_ADDR; // R1 R2
  // Table start ignores the fuse; only the relocate bit moves it
  assign table_start = vector_table_relocate ? (BOOT_START + RVS_TABLE_OFFSET) : RVS_TABLE_OFFSET; // R4 R5 R6 R16
  // One word per vector
  assign irq_addr    = table_start + RVS_PC_WIDTH'(pick.index); // R7 R8 R9 R10 R11 R12 R13 R14 R17
  assign irq_num     = RVS_FIRST_IRQ_NUM + pick.index;
  assign take_irq    = (state == RVS_ST_RUN) && core_take && pick.any;

  // ==========================================================
  // Sequencer
  // The gap cycle gives the source one edge to drop its request
  // after the acknowledge, so one event is not taken twice.
  always_comb begin
    next_state = state;
    unique case (state)
      RVS_ST_BOOT: begin
        next_state = RVS_ST_RUN;
      end
      RVS_ST_RUN: begin
        if (take_irq) begin
          next_state = RVS_ST_GAP;
        end
      end
      RVS_ST_GAP: begin
        next_state = RVS_ST_RUN;
      end
      // Unused code falls back to the reset vector load
      default: begin
        next_state = RVS_ST_BOOT;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= RVS_ST_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // Fuse is caught on the first edge after release
  always_ff @(posedge clk) begin
    if (!resetn) begin
      boot_reset_active <= 1'b0;
    end else if (state == RVS_ST_BOOT) begin
      boot_reset_active <= fuse_programmed; // R2
    end
  end

  // ==========================================================
  // Outputs to the core, pulses last one cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_load        <= 1'b0;
      pc_from_reset  <= 1'b0;
      irq_ack        <= 1'b0;
      pc_next        <= RVS_RESET_ADDR;
      irq_vector_num <= '0;
    end else begin
      pc_load       <= (state == RVS_ST_BOOT) || take_irq; // R19
      pc_from_reset <= (state == RVS_ST_BOOT);
      irq_ack       <= take_irq;
      if (state == RVS_ST_BOOT) begin
        pc_next <= reset_addr; // R1
      end else if (take_irq) begin
        pc_next        <= irq_addr; // R19
        irq_vector_num <= irq_num;
      end
    end
  end

  // ==========================================================
  // Checks
  logic [RVS_PC_WIDTH-1:0]  exp_start;
  logic [RVS_IDX_WIDTH-1:0] exp_index;
  logic                     lower_waiting;

  // Table start as it stood at the take edge
  always_ff @(posedge clk) begin
    exp_start <= vector_table_relocate ? (BOOT_START + 12'h001) : 12'h001;
  end

  assign exp_index = RVS_IDX_WIDTH'(irq_vector_num - 5'h02);

  // Any pending source below the one picked
  always_comb begin
    lower_waiting = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (irq_pending[i] && (i < int'(pick.index))) begin
        lower_waiting = 1'b1;
      end
    end
  end

  a_reset_vector_addr: assert property ( // R1 R3
    @(posedge clk) disable iff (!resetn)
    pc_from_reset |-> (pc_next == ($past(fuse_sync) ? 12'h000 : BOOT_START)))
    else $error("reset vector address wrong");

  a_boot_fuse_flag: assert property ( // R2
    @(posedge clk) disable iff (!resetn)
    pc_from_reset |-> (boot_reset_active == (pc_next == BOOT_START)))
    else $error("boot flag disagrees with reset address");

  a_reset_once_first: assert property ( // R1
    @(posedge clk)
    (!resetn ##1 resetn) |=> (pc_load && pc_from_reset))
    else $error("no reset load after release");

  a_table_start_sel: assert property ( // R4 R5 R6 R17
    @(posedge clk) disable iff (!resetn)
    irq_ack |-> (pc_next == exp_start + RVS_PC_WIDTH'(exp_index)))
    else $error("vector address off table");

  a_ext_zero_vec: assert property ( // R7
    @(posedge clk) disable iff (!resetn)
    (irq_ack && irq_vector_num == 5'h02 && !$past(vector_table_relocate)) |-> (pc_next == 12'h001))
    else $error("external request zero misplaced");

  a_store_ready_vec: assert property ( // R14
    @(posedge clk) disable iff (!resetn)
    (irq_ack && irq_vector_num == 5'h1A && !$past(vector_table_relocate)) |-> (pc_next == 12'h019))
    else $error("program store ready misplaced");

  a_lowest_wins: assert property ( // R18
    @(posedge clk) disable iff (!resetn)
    take_irq |-> !lower_waiting)
    else $error("higher vector chosen over lower");

  a_ack_one_cycle: assert property ( // R19
    @(posedge clk) disable iff (!resetn)
    (state == RVS_ST_RUN && core_take && pick.any) |=> (irq_ack && pc_load && !pc_from_reset) ##1 !irq_ack)
    else $error("acknowledge not a single pulse");

  a_ack_identity: assert property ( // R19
    @(posedge clk) disable iff (!resetn)
    irq_ack |-> (irq_vector_num == $past(pick.index) + 5'h02))
    else $error("acknowledged identity wrong");

  a_no_take_idle: assert property ( // R19
    @(posedge clk) disable iff (!resetn)
    !$past(take_irq) && !pc_from_reset |-> !pc_load)
    else $error("load without cause");

  c_boot_reset: cover property (
    @(posedge clk) pc_from_reset && boot_reset_active);

  c_relocated_irq: cover property (
    @(posedge clk) disable iff (!resetn)
    irq_ack && (pc_next > BOOT_START));

  c_two_pending: cover property (
    @(posedge clk) disable iff (!resetn)
    take_irq && $countones(irq_pending) > 1);

  c_back_to_back: cover property (
    @(posedge clk) disable iff (!resetn)
    irq_ack ##2 irq_ack);

endmodule // rvs_vector_select

// ===== tb/rvs_core_model.sv
`timescale 1ns/1ps
// ==========================================
// Core side: says when it can accept an interrupt
module rvs_core_model
  import rvs_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic irq_enable,
  input  wire logic slow,
  output logic      core_take
);
  logic phase;

  initial begin
    phase = 1'b0;
  end

  // Slow core is ready every other cycle only
  always @(posedge clk) begin
    phase <= resetn ? ~phase : 1'b0;
  end

  // Follows the enable at once, so turning interrupts off blocks the very next edge
  assign core_take = irq_enable & (~slow | phase);
endmodule // rvs_core_model

// ===== tb/test_reset_and_vector_address_select.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the reset and vector address select
module test_reset_and_vector_address_select;
  import rvs_pkg::*;
  localparam logic [11:0] BOOT = 12'h800;
  logic        clk, resetn, fuse, reloc, irq_en, slow, core_take;
  logic        pc_load, pc_from_reset, irq_ack, boot_act;
  logic [24:0] pend;
  logic [11:0] pc_next;
  logic [4:0]  vnum;
  int          err_count, num_checks;

  rvs_vector_select #(.NUM_SOURCES(25), .BOOT_START(BOOT)) rvs_vector_select_i (
    .clk(clk), .resetn(resetn), .boot_reset_fuse(fuse), .vector_table_relocate(reloc),
    .irq_pending(pend), .core_take(core_take), .pc_load(pc_load), .pc_next(pc_next),
    .pc_from_reset(pc_from_reset), .irq_ack(irq_ack), .irq_vector_num(vnum),
    .boot_reset_active(boot_act));

  rvs_core_model rvs_core_model_i (
    .clk(clk), .resetn(resetn), .irq_enable(irq_en), .slow(slow), .core_take(core_take));

  // ==========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Whole run is about 140 cycles; this leaves a wide margin
  initial begin
    #100000;
    err_count++;
    final_report;
  end

  // ==========================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Fuse must stay stable while reset is held
  task automatic do_reset(input logic f);
    @(negedge clk);
    resetn = 1'b0;
    fuse   = f;
    pend   = '0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check(16'(pc_load), 16'h0001);
    check(16'(pc_from_reset), 16'h0001);
    check(16'(pc_next), f ? 16'h0000 : 16'(BOOT));
    check(16'(boot_act), 16'(!f));
    @(negedge clk);
    check(16'(pc_from_reset), 16'h0000);
  endtask

  // Raise requests, wait for the ack, drop the winner as a source would
  task automatic take(input logic [24:0] m, input int idx, input logic r);
    int n;
    n     = 0;
    reloc = r;
    pend  = pend | m;
    do begin
      @(negedge clk);
      n++;
    end while (irq_ack !== 1'b1 && n < 8);
    pend[idx] = 1'b0;
    if (!slow) check(16'(n), 16'h0001);
    check(16'(irq_ack), 16'h0001);
    check(16'(pc_next), 16'((r ? BOOT : 12'h000) + 12'h001 + 12'(idx)));
    check(16'(vnum), 16'(idx + 2));
    @(negedge clk);
    check(16'(pc_load), 16'h0000);
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // Scenarios
  initial begin
    resetn     = 1'b0;
    fuse       = 1'b1;
    reloc      = 1'b0;
    irq_en     = 1'b1;
    slow       = 1'b0;
    pend       = '0;
    err_count  = 0;
    num_checks = 0;
    do_reset(1'b1);
    // Every source in both table positions
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 25; i++) begin
        take(25'h0000001 << i, i, r[0]);
      end
    end
    // Three pending at once, served lowest first, back to back
    take(25'h1100008, 3, 1'b0);
    take(25'h0000000, 20, 1'b0);
    take(25'h0000000, 24, 1'b0);
    // Core not accepting: a pending request must not load the counter
    irq_en = 1'b0;
    pend   = 25'h0000001;
    repeat (4) begin
      @(negedge clk);
      check(16'(pc_load), 16'h0000);
    end
    irq_en = 1'b1;
    take(25'h0000000, 0, 1'b0);
    // Programmed fuse, table placement stays independent of it
    do_reset(1'b0);
    take(25'h0000010, 4, 1'b0);
    take(25'h0000010, 4, 1'b1);
    // Slow core still gets the right vector
    slow = 1'b1;
    take(25'h0000400, 10, 1'b1);
    take(25'h1000000, 24, 1'b0);
    final_report;
  end
endmodule // test_reset_and_vector_address_select
